// file: hdl/serdes_pcs_mode_control_regs.svh
// Register offsets, field positions, reset values and write mask for the PCS mode control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses; registers are 16 bits wide in the low lanes.
//
// Notes on behaviour
// [RQ1] Comma detection runs only while comma_detect_on is one; it resets to one.
// [RQ2] crc_check_off gates the CRC checker clock; it resets to one.
// [RQ3] PLL powers down on control bit 11 unless pll_keep_alive is one.
// [RQ4] PHY-side SGMII with autoneg sends word: bit15 one, bit14 ack, bit13 zero, low 0x001.
// [RQ5] PHY-side word copies control bit 8 to 12, bit 6 to 11, bit 13 to 10.
// [RQ6] PHY-side SGMII: control bit 11 one takes link down, zero lets it up.
// [RQ7] Autodetect on (reset) toggles fiber/SGMII on each page with wrong selector bit 0.
// [RQ8] Autodetect off: mode comes only from fiber_select.
// [RQ9] sigdet_polarity_flip one inverts the signal-detect pin; zero uses it unchanged.
// [RQ10] Signal-detect requirement one: sync only while signal detect asserted; zero ignores it.
// [RQ11] In SGMII mode signal detect never affects synchronization.
// [RQ12] ten_bit_select zero selects GMII, one selects ten-bit interface; resets to zero.
// [RQ13] fiber_select zero is SGMII, one is 1000X fiber; resets to zero.
// [RQ14] Control bits read back as written except SERDES control one bit 15, which reads zero; link-side bits act a few link cycles later.
`ifndef SERDES_PCS_MODE_CONTROL_REGS_SVH
`define SERDES_PCS_MODE_CONTROL_REGS_SVH

`define ADDR_BASIC_CONTROL    8'h00
`define ADDR_LINK_STATUS      8'h04
`define ADDR_SERDES_CTRL_ONE  8'h20

`define RST_BASIC_CONTROL     16'h1140
`define RST_SERDES_CTRL_ONE   16'h0190
`define MASK_SERDES_CTRL_ONE  16'h7fff

`define BIT_SPEED_LSB         13
`define BIT_AN_ENABLE         12
`define BIT_POWER_DOWN        11
`define BIT_FULL_DUPLEX       8
`define BIT_SPEED_MSB         6

`define BIT_COMMA_DETECT_ON   8
`define BIT_CRC_CHECK_OFF     7
`define BIT_PLL_KEEP_ALIVE    6
`define BIT_PHY_SIDE_MODE     5
`define BIT_MODE_AUTODETECT   4
`define BIT_SIGDET_FLIP       3
`define BIT_SIGDET_REQUIRED   2
`define BIT_TEN_BIT_SELECT    1
`define BIT_FIBER_SELECT      0

`define BIT_PAGE_SELECTOR     0
`define PHY_WORD_LOW          10'h001

`endif

// file: hdl/serdes_pcs_mode_control_pkg.sv
// Types shared by the PCS mode control block.
// Assumes the constants header is included by the design file.
package serdes_pcs_mode_control_pkg;

    // Settings handed from the register domain to the link domain
    typedef struct packed {
        logic pwr_down;
        logic speed_lsb;
        logic full_duplex;
        logic speed_msb;
        logic an_enable;
        logic phy_side_mode;
        logic mode_autodetect_on;
        logic fiber_select;
        logic sigdet_polarity_flip;
        logic sigdet_required;
        logic comma_detect_on;
        logic crc_check_off;
    } link_cfg_t;

    // Link state reported back to the register domain
    typedef struct packed {
        logic fiber_active;
        logic sync_ok;
        logic link_up;
        logic partner_ack;
    } link_stat_t;

endpackage

// file: hdl/serdes_pcs_mode_control.sv
// PCS mode control: register file on Wishbone and the mode, sync and code word logic at the link.
// Assumes settings change rarely; rst_i is synchronous to clk_i and is re-synchronised for the link side.
`timescale 1ns/1ps
`include "serdes_pcs_mode_control_regs.svh"

module serdes_pcs_mode_control #(
    parameter int unsigned ADDR_W = 8
) (
    // System clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Register domain outputs
    output logic                   pll_power_down_o,
    output logic                   ten_bit_select_o,
    // Link clock and receive side
    input  wire logic              link_clk_i,
    input  wire logic              sigdet_pin_i,
    input  wire logic              rx_comma_i,
    input  wire logic              rx_page_valid_i,
    input  wire logic [15:0]       rx_page_i,
    // Link side outputs
    output logic                   comma_detect_o,
    output logic                   crc_clk_en_o,
    output logic                   fiber_mode_o,
    output logic                   sync_ok_o,
    output logic                   link_up_o,
    output logic                   tx_word_valid_o,
    output logic      [15:0]       tx_word_o
);

    // Register domain state
    typedef struct packed {
        logic [15:0]                                basic;
        logic [15:0]                                ctrl_one;
        logic                                       ack;
        logic [31:0]                                dat;
        serdes_pcs_mode_control_pkg::link_cfg_t     cfg;
        logic                                       pll_down;
        serdes_pcs_mode_control_pkg::link_stat_t    st_s1;
        serdes_pcs_mode_control_pkg::link_stat_t    st_s2;
        serdes_pcs_mode_control_pkg::link_stat_t    st_s3;
        serdes_pcs_mode_control_pkg::link_stat_t    st_q;
    } sys_state_t;

    // Link domain state
    typedef struct packed {
        logic                                       rst_s1;
        logic                                       rst_s2;
        serdes_pcs_mode_control_pkg::link_cfg_t     cfg_s1;
        serdes_pcs_mode_control_pkg::link_cfg_t     cfg_s2;
        serdes_pcs_mode_control_pkg::link_cfg_t     cfg_s3;
        serdes_pcs_mode_control_pkg::link_cfg_t     cfg_q;
        logic                                       sd_s1;
        logic                                       sd_s2;
        logic                                       rx_comma;
        logic                                       page_valid;
        logic [15:0]                                page;
        logic                                       fiber_active;
        logic                                       partner_ack;
        logic                                       sync_ok;
        logic                                       link_up;
        logic                                       comma_det;
        logic                                       crc_en;
        logic                                       tx_valid;
        logic [15:0]                                tx_word;
        serdes_pcs_mode_control_pkg::link_stat_t    stat;
    } link_state_t;

    sys_state_t  sys_r;
    sys_state_t  sys_nxt;
    link_state_t lnk_r;
    link_state_t lnk_nxt;

    // Byte-lane merge of a 16-bit register held in the low two lanes
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [31:0] wr_v,
                                               input logic [3:0]  sel_v);
        logic [15:0] res;
        res = old_v;
        if (sel_v[0]) begin
            res[7:0] = wr_v[7:0];
        end
        if (sel_v[1]) begin
            res[15:8] = wr_v[15:8];
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Register domain
    // ------------------------------------------------------------------
    always_comb begin
        logic req;
        logic [ADDR_W-1:0] adr;
        logic [15:0] rd16;
        req     = 1'b0;
        adr     = '0;
        rd16    = 16'h0000;
        sys_nxt = sys_r;

        // Answer one cycle after the request is seen, then drop ack for a cycle
        req         = wb_cyc_i && wb_stb_i && !sys_r.ack;
        adr         = wb_adr_i;
        sys_nxt.ack = req;

        case (adr)
            ADDR_W'(`ADDR_BASIC_CONTROL): begin
                rd16 = sys_r.basic;
            end
            ADDR_W'(`ADDR_SERDES_CTRL_ONE): begin
                rd16 = sys_r.ctrl_one; // RQ14
            end
            ADDR_W'(`ADDR_LINK_STATUS): begin
                rd16 = {12'h000, sys_r.st_q};
            end
            default: begin
                rd16 = 16'h0000;
            end
        endcase

        if (req) begin
            sys_nxt.dat = {16'h0000, rd16};
        end

        // Unmapped and status addresses take writes without effect
        if (req && wb_we_i) begin
            case (adr)
                ADDR_W'(`ADDR_BASIC_CONTROL): begin
                    sys_nxt.basic = lane_merge(sys_r.basic, wb_dat_i, wb_sel_i);
                end
                ADDR_W'(`ADDR_SERDES_CTRL_ONE): begin
                    sys_nxt.ctrl_one = lane_merge(sys_r.ctrl_one, wb_dat_i, wb_sel_i)
                                       & `MASK_SERDES_CTRL_ONE; // RQ14
                end
                default: begin
                    sys_nxt.ctrl_one = sys_r.ctrl_one;
                end
            endcase
        end

        // PLL follows power-down unless kept alive for the 125 MHz clock user
        sys_nxt.pll_down = sys_r.basic[`BIT_POWER_DOWN]
                           && !sys_r.ctrl_one[`BIT_PLL_KEEP_ALIVE]; // RQ3

        // Link status comes back through two flops and is taken once two samples agree
        sys_nxt.st_s1 = lnk_r.stat;
        sys_nxt.st_s2 = sys_r.st_s1;
        sys_nxt.st_s3 = sys_r.st_s2;
        if (sys_r.st_s2 == sys_r.st_s3) begin
            sys_nxt.st_q = sys_r.st_s3;
        end

        if (rst_i) begin
            sys_nxt          = '0;
            sys_nxt.basic    = `RST_BASIC_CONTROL;
            sys_nxt.ctrl_one = `RST_SERDES_CTRL_ONE; // RQ1 RQ2 RQ12 RQ13
        end

        // Settings leave from flops; in reset they carry the defaults, never all zero
        sys_nxt.cfg.pwr_down             = sys_nxt.basic[`BIT_POWER_DOWN];
        sys_nxt.cfg.speed_lsb            = sys_nxt.basic[`BIT_SPEED_LSB];
        sys_nxt.cfg.full_duplex          = sys_nxt.basic[`BIT_FULL_DUPLEX];
        sys_nxt.cfg.speed_msb            = sys_nxt.basic[`BIT_SPEED_MSB];
        sys_nxt.cfg.an_enable            = sys_nxt.basic[`BIT_AN_ENABLE];
        sys_nxt.cfg.phy_side_mode        = sys_nxt.ctrl_one[`BIT_PHY_SIDE_MODE];
        sys_nxt.cfg.mode_autodetect_on   = sys_nxt.ctrl_one[`BIT_MODE_AUTODETECT];
        sys_nxt.cfg.fiber_select         = sys_nxt.ctrl_one[`BIT_FIBER_SELECT];
        sys_nxt.cfg.sigdet_polarity_flip = sys_nxt.ctrl_one[`BIT_SIGDET_FLIP];
        sys_nxt.cfg.sigdet_required      = sys_nxt.ctrl_one[`BIT_SIGDET_REQUIRED];
        sys_nxt.cfg.comma_detect_on      = sys_nxt.ctrl_one[`BIT_COMMA_DETECT_ON];
        sys_nxt.cfg.crc_check_off        = sys_nxt.ctrl_one[`BIT_CRC_CHECK_OFF];
    end

    always_ff @(posedge clk_i) begin
        sys_r <= sys_nxt;
    end

    assign wb_ack_o         = sys_r.ack;
    assign wb_dat_o         = sys_r.dat;
    assign pll_power_down_o = sys_r.pll_down;
    assign ten_bit_select_o = sys_r.ctrl_one[`BIT_TEN_BIT_SELECT]; // RQ12

    // ------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------
    // Settings cross as a word: two flops per bit, then held until two samples agree,
    // so a half-updated set never acts. Costs a few link cycles of latency.
    always_comb begin
        serdes_pcs_mode_control_pkg::link_cfg_t c;
        logic sgmii;
        logic sd_eff;
        logic sd_ok;
        logic mode_fiber;
        logic wrong_sel;
        c          = '0;
        sgmii      = 1'b0;
        sd_eff     = 1'b0;
        sd_ok      = 1'b0;
        mode_fiber = 1'b0;
        wrong_sel  = 1'b0;
        lnk_nxt    = lnk_r;

        lnk_nxt.rst_s1 = rst_i;
        lnk_nxt.rst_s2 = lnk_r.rst_s1;
        lnk_nxt.cfg_s1 = sys_r.cfg;
        lnk_nxt.cfg_s2 = lnk_r.cfg_s1;
        lnk_nxt.cfg_s3 = lnk_r.cfg_s2;
        if (lnk_r.cfg_s2 == lnk_r.cfg_s3) begin
            lnk_nxt.cfg_q = lnk_r.cfg_s3;
        end
        lnk_nxt.sd_s1  = sigdet_pin_i;
        lnk_nxt.sd_s2  = lnk_r.sd_s1;

        // Same-domain receive inputs are registered once to align with the settings
        lnk_nxt.rx_comma   = rx_comma_i;
        lnk_nxt.page_valid = rx_page_valid_i;
        lnk_nxt.page       = rx_page_i;

        c = lnk_r.cfg_q;

        // Mode: fixed by fiber_select, or toggled by mismatched pages
        if (!c.mode_autodetect_on) begin
            mode_fiber = c.fiber_select; // RQ8 RQ13
        end else begin
            wrong_sel = lnk_r.page_valid
                        && (lnk_r.page[`BIT_PAGE_SELECTOR] == lnk_r.fiber_active);
            mode_fiber = wrong_sel ? !lnk_r.fiber_active : lnk_r.fiber_active; // RQ7
        end
        lnk_nxt.fiber_active = mode_fiber;
        sgmii = !lnk_r.fiber_active;

        // Signal detect path
        sd_eff = lnk_r.sd_s2 ^ c.sigdet_polarity_flip; // RQ9
        sd_ok  = sgmii || !c.sigdet_required || sd_eff; // RQ10 RQ11

        // Comma detection only while enabled; sync needs a comma and an allowed signal detect
        lnk_nxt.comma_det = c.comma_detect_on && lnk_r.rx_comma; // RQ1
        if (!sd_ok || !c.comma_detect_on) begin
            lnk_nxt.sync_ok = 1'b0; // RQ10
        end else if (lnk_nxt.comma_det) begin
            lnk_nxt.sync_ok = 1'b1;
        end

        // Partner acknowledge seen on a received page; cleared with autoneg off
        if (!c.an_enable) begin
            lnk_nxt.partner_ack = 1'b0;
        end else if (lnk_r.page_valid) begin
            lnk_nxt.partner_ack = 1'b1;
        end

        // Power-down bit holds the link down only in PHY-side SGMII
        lnk_nxt.link_up = lnk_r.sync_ok
                          && !(c.phy_side_mode && sgmii && c.pwr_down); // RQ6

        // PHY-side code word
        lnk_nxt.tx_valid = c.phy_side_mode && sgmii && c.an_enable; // RQ4
        if (lnk_nxt.tx_valid) begin
            lnk_nxt.tx_word = {1'b1, lnk_r.partner_ack, 1'b0,
                               c.full_duplex, c.speed_msb, c.speed_lsb,
                               `PHY_WORD_LOW}; // RQ4 RQ5
        end else begin
            lnk_nxt.tx_word = 16'h0000;
        end

        // Clock enable for the CRC checker's gate cell
        lnk_nxt.crc_en = !c.crc_check_off; // RQ2

        lnk_nxt.stat.fiber_active = lnk_r.fiber_active;
        lnk_nxt.stat.sync_ok      = lnk_r.sync_ok;
        lnk_nxt.stat.link_up      = lnk_r.link_up;
        lnk_nxt.stat.partner_ack  = lnk_r.partner_ack;

        // Reset holds the settings path open so defaults arrive before release
        if (lnk_r.rst_s2) begin
            lnk_nxt              = '0;
            lnk_nxt.rst_s1       = rst_i;
            lnk_nxt.rst_s2       = lnk_r.rst_s1;
            lnk_nxt.cfg_s1       = sys_r.cfg;
            lnk_nxt.cfg_s2       = lnk_r.cfg_s1;
            lnk_nxt.cfg_s3       = lnk_r.cfg_s2;
            lnk_nxt.cfg_q        = lnk_r.cfg_s3;
            lnk_nxt.sd_s1        = sigdet_pin_i;
            lnk_nxt.sd_s2        = lnk_r.sd_s1;
            lnk_nxt.fiber_active = c.fiber_select; // RQ13
        end
    end

    always_ff @(posedge link_clk_i) begin
        lnk_r <= lnk_nxt;
    end

    assign comma_detect_o  = lnk_r.comma_det;
    assign crc_clk_en_o    = lnk_r.crc_en;
    assign fiber_mode_o    = lnk_r.fiber_active;
    assign sync_ok_o       = lnk_r.sync_ok;
    assign link_up_o       = lnk_r.link_up;
    assign tx_word_valid_o = lnk_r.tx_valid;
    assign tx_word_o       = lnk_r.tx_word;

endmodule // serdes_pcs_mode_control

// file: verification/pcs_mode_monitor.sv
// Port checks for the PCS mode control block.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "serdes_pcs_mode_control_regs.svh"
module pcs_mode_monitor #(
    parameter int unsigned ADDR_W = 8
) (
    // Register side
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              pll_power_down_o,
    input wire logic              ten_bit_select_o,
    // Link side
    input wire logic              link_clk_i,
    input wire logic              rx_comma_i,
    input wire logic              comma_detect_o,
    input wire logic              crc_clk_en_o,
    input wire logic              fiber_mode_o,
    input wire logic              sync_ok_o,
    input wire logic              tx_word_valid_o,
    input wire logic [15:0]       tx_word_o
);
    // Shadow of written bits; byte enables ignored, as every bench write enables the lane of each shadowed bit
    logic [2:0] sh_r;
    logic [2:0] prev_r;
    logic       take;
    assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    always_ff @(posedge clk_i) begin
        prev_r <= rst_i ? 3'h0 : sh_r;
        if (rst_i) sh_r <= 3'h0;
        else if (take && wb_adr_i == ADDR_W'(`ADDR_BASIC_CONTROL)) sh_r[2] <= wb_dat_i[`BIT_POWER_DOWN];
        else if (take && wb_adr_i == ADDR_W'(`ADDR_SERDES_CTRL_ONE)) sh_r[1:0] <= {wb_dat_i[6], wb_dat_i[1]};
    end
    property p_ack_take;
        @(posedge clk_i) disable iff (rst_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_rd_upper;
        @(posedge clk_i) disable iff (rst_i) wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000;
    endproperty
    property p_pll;
        @(posedge clk_i) disable iff (rst_i) (sh_r == prev_r) [*2] |-> pll_power_down_o == (sh_r[2] && !sh_r[1]);
    endproperty
    property p_tbi;
        @(posedge clk_i) disable iff (rst_i) (sh_r == prev_r) [*2] |-> ten_bit_select_o == sh_r[0];
    endproperty
    property p_comma;
        @(posedge link_clk_i) disable iff (rst_i) comma_detect_o |-> $past(rx_comma_i, 2);
    endproperty
    property p_crc_reset;
        @(posedge link_clk_i) disable iff (rst_i) $fell(rst_i) |-> !crc_clk_en_o [*2];
    endproperty
    property p_sync;
        @(posedge link_clk_i) disable iff (rst_i) $rose(sync_ok_o) |-> comma_detect_o;
    endproperty
    property p_tx_word;
        @(posedge link_clk_i) disable iff (rst_i)
            tx_word_valid_o |-> tx_word_o[15] && !tx_word_o[13] && tx_word_o[9:0] == `PHY_WORD_LOW;
    endproperty
    property p_tx_idle;
        @(posedge link_clk_i) disable iff (rst_i) !tx_word_valid_o |-> tx_word_o == 16'h0000;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack missing after request");
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper half not zero");
    a_pll: assert property (p_pll) else $error("pll power down wrong");
    a_tbi: assert property (p_tbi) else $error("interface select wrong");
    a_comma: assert property (p_comma) else $error("comma detect without comma");
    a_crc_reset: assert property (p_crc_reset) else $error("crc clock enabled after reset");
    a_sync: assert property (p_sync) else $error("sync without comma");
    a_tx_word: assert property (p_tx_word) else $error("phy code word fixed bits wrong");
    a_tx_idle: assert property (p_tx_idle) else $error("code word not zero when idle");
    c_write: cover property (@(posedge clk_i) disable iff (rst_i) wb_we_i && wb_ack_o);
    c_tx: cover property (@(posedge link_clk_i) disable iff (rst_i) tx_word_valid_o);
    c_fiber: cover property (@(posedge link_clk_i) disable iff (rst_i) $rose(fiber_mode_o));
    c_sync: cover property (@(posedge link_clk_i) disable iff (rst_i) $rose(sync_ok_o));
endmodule // pcs_mode_monitor
bind serdes_pcs_mode_control pcs_mode_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_power_down_o, .ten_bit_select_o, .link_clk_i,
    .rx_comma_i, .comma_detect_o, .crc_clk_en_o, .fiber_mode_o, .sync_ok_o, .tx_word_valid_o, .tx_word_o);

// file: verification/link_peer.sv
// Serial link partner model: commas, autoneg pages and the signal-detect pin.
// Assumes the bench calls its tasks; all changes follow the link clock.
`timescale 1ns/1ps
module link_peer (
    // Link clock
    input  wire logic        link_clk_i,
    // Toward the block
    output logic             sigdet_pin_o,
    output logic             rx_comma_o,
    output logic             rx_page_valid_o,
    output logic      [15:0] rx_page_o
);
    initial begin
        sigdet_pin_o = 1'b0;
        rx_comma_o = 1'b0;
        rx_page_valid_o = 1'b0;
        rx_page_o = 16'ha5c3;
    end
    // A gap makes the partner slow to answer
    task automatic send_comma(input int gap);
        repeat (gap + 1) @(posedge link_clk_i);
        rx_comma_o <= 1'b1;
        @(posedge link_clk_i);
        rx_comma_o <= 1'b0;
    endtask
    // Word bus shows the inverse outside a page so stale data never matches
    task automatic send_page(input logic [15:0] pg, input int gap);
        repeat (gap + 1) @(posedge link_clk_i);
        rx_page_valid_o <= 1'b1;
        rx_page_o <= pg;
        @(posedge link_clk_i);
        rx_page_valid_o <= 1'b0;
        rx_page_o <= ~pg;
    endtask
    task automatic set_sigdet(input logic v);
        @(posedge link_clk_i);
        sigdet_pin_o <= v;
    endtask
endmodule // link_peer

// file: verification/tb.sv
// Self-checking bench for the PCS mode control block.
// Assumes the monitor bind and the link peer model are compiled first.
`timescale 1ns/1ps
`include "serdes_pcs_mode_control_regs.svh"
module tb;
    logic        clk_i = 1'b0;
    logic        link_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    logic [31:0] seed = 32'hcd4b3695;
    logic        ef;
    wire  [31:0] dat_o;
    wire  [15:0] pg, txw;
    wire         ack, pll, tbi, sd, cm, pv, cmo, crc, fib, sync, lup, txv;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          ncomma = 0;
    int          c0;
    serdes_pcs_mode_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .pll_power_down_o(pll), .ten_bit_select_o(tbi), .link_clk_i(link_clk_i), .sigdet_pin_i(sd),
        .rx_comma_i(cm), .rx_page_valid_i(pv), .rx_page_i(pg), .comma_detect_o(cmo), .crc_clk_en_o(crc),
        .fiber_mode_o(fib), .sync_ok_o(sync), .link_up_o(lup), .tx_word_valid_o(txv), .tx_word_o(txw));
    link_peer i_peer (.link_clk_i(link_clk_i), .sigdet_pin_o(sd), .rx_comma_o(cm), .rx_page_valid_o(pv),
        .rx_page_o(pg));
    always #5 clk_i = ~clk_i;
    initial begin
        #2.1;
        forever #7.5 link_clk_i = ~link_clk_i;
    end
    always @(posedge link_clk_i) if (cmo === 1'b1) ncomma++;
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    // Holds the request until ack is sampled, then idles one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            n++;
            if (n > 20) begin
                miscompares++;
                test_done();
            end
            @(posedge clk_i);
        end
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk("register", e, q);
    endtask
    task automatic lw(input int n);
        repeat (n) @(posedge link_clk_i);
        @(posedge clk_i);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    initial begin
        repeat (100000) @(posedge clk_i);
        miscompares++;
        test_done();
    end
    initial begin
        // Link side needs four of its own edges in reset
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`ADDR_SERDES_CTRL_ONE, 32'(`RST_SERDES_CTRL_ONE));
        rd(`ADDR_BASIC_CONTROL, 32'(`RST_BASIC_CONTROL));
        lw(6);
        chk("crc_en", 0, crc);
        chk("fiber", 0, fib);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wb(1'b1, `ADDR_SERDES_CTRL_ONE, seed);
            rd(`ADDR_SERDES_CTRL_ONE, {16'h0, seed[15:0] & `MASK_SERDES_CTRL_ONE});
        end
        sel <= 4'h1;
        wb(1'b1, `ADDR_SERDES_CTRL_ONE, ~seed);
        rd(`ADDR_SERDES_CTRL_ONE, {16'h0, seed[15:8] & 8'h7f, ~seed[7:0]});
        sel <= 4'hf;
        wb(1'b1, 8'h40, seed);
        rd(8'h40, 32'h0);
        $display("test readback done");
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, `ADDR_BASIC_CONTROL, {20'h0, i[0], 11'h0});
            wb(1'b1, `ADDR_SERDES_CTRL_ONE, {25'h0, i[1], 4'h0, i[0], 1'b0});
            @(posedge clk_i);
            chk("pll_down", {31'h0, i[0] & !i[1]}, {31'h0, pll});
            chk("ten_bit", {31'h0, i[0]}, {31'h0, tbi});
        end
        $display("test pll done");
        wb(1'b1, `ADDR_SERDES_CTRL_ONE, 32'h0100);
        lw(6);
        chk("crc_en", 1, crc);
        c0 = ncomma;
        i_peer.send_comma(0);
        lw(6);
        chk("comma_on", c0 + 1, ncomma);
        wb(1'b1, `ADDR_SERDES_CTRL_ONE, 32'h0000);
        lw(6);
        c0 = ncomma;
        i_peer.send_comma(3);
        lw(6);
        chk("comma_off", c0, ncomma);
        chk("comma_idle", 0, cmo);
        $display("test comma done");
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            wb(1'b1, `ADDR_SERDES_CTRL_ONE, {23'h0, 1'b1, 4'h0, i[2], i[1], 1'b0, i[0]});
            i_peer.set_sigdet(i[3]);
            lw(8);
            i_peer.send_comma(seed[1:0]);
            lw(6);
            chk("fiber", {31'h0, i[0]}, {31'h0, fib});
            chk("sync", {31'h0, !(i[0] && i[1]) || (i[3] ^ i[2])}, {31'h0, sync});
        end
        $display("test sigdet done");
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        lw(6);
        ef = 1'b0;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            i_peer.send_page(seed[15:0], seed[17:16]);
            if (seed[0] == ef) ef = !ef;
            lw(5);
            chk("fiber", {31'h0, ef}, {31'h0, fib});
        end
        i_peer.send_page({15'h0, ef}, 0);
        i_peer.send_page({15'h0, !ef}, 0);
        lw(5);
        chk("fiber", {31'h0, ef}, {31'h0, fib});
        $display("test autodetect done");
        seed = xs(seed);
        wb(1'b1, `ADDR_SERDES_CTRL_ONE, 32'h0120);
        wb(1'b1, `ADDR_BASIC_CONTROL, 32'h1000 | (seed & 32'h2140));
        lw(6);
        i_peer.send_page(seed[31:16], 0);
        i_peer.send_comma(0);
        lw(8);
        chk("tx_valid", 1, txv);
        chk("tx_word", {16'h0, 3'b110, seed[8], seed[6], seed[13], 10'h001}, txw);
        chk("link_up", 1, lup);
        rd(`ADDR_LINK_STATUS, 32'h7);
        wb(1'b1, `ADDR_BASIC_CONTROL, 32'h1800 | (seed & 32'h2140));
        lw(8);
        chk("link_up", 0, lup);
        $display("test phy side done");
        test_done();
    end
endmodule // tb
